// ---- common/dim_cal_defines.vh ----
// Constants for the analog dimming and offset calibration block.
// Included by the design file; definitions only.
`ifndef DIM_CAL_DEFINES_VH
`define DIM_CAL_DEFINES_VH
// Register offsets
`define ADDR_DIM0 4'h0
`define ADDR_DIM1 4'h1
`define ADDR_CAL0 4'h2
`define ADDR_CAL1 4'h3
`define ADDR_LOOP 4'h4
`define ADDR_STAT 4'h5
`define ADDR_IRQ_ST 4'h6
`define ADDR_IRQ_MSK 4'h7
// Current cal register fields
`define CAL_EXTREF_BIT 0
`define CAL_START_BIT 1
`define CAL_DONE_BIT 2
`define CAL_VAL_LSB 8
// Loop control fields: bit n is channel n
`define LOOP_CALEN_LSB 0
`define LOOP_PWM_LSB 4
// Interrupt status bits per channel: done at 2*ch, stop at 2*ch+1
`define IRQ_DONE_OFS 0
`define IRQ_STOP_OFS 1
// Reset values
`define DIM_RST 8'hFF
`define CAL_VAL_RST 8'h00
// Timing
`define CAL_TIME_US 200
`define CLK_MHZ 200
`define CAL_CYCLES (`CAL_TIME_US * `CLK_MHZ)
`define SOFT_START_CYCLES 1000
`endif

// ---- verilog/dim_cal_ctrl.v ----
// Two-channel analog dimming reference select, stop/soft-start and offset calibration.
// Assumes pins and comparator outputs are asynchronous; register port on sys_clk_i.
//
// Summary of operation
// - Reference-select high routes the set pin to the error amplifier reference.
// - Reference-select low uses the 8-bit register dimming level via the DAC.
// - With reference-select low, dimming value zero stops switching; nonzero restarts through soft start.
// - Limp-home is entered only while the limp-home pin is high.
// - In limp-home, switching needs both direct dim input and enable high.
// - In limp-home, dimming level comes from the set pin.
// - Set pin below 100 mV stops; above 200 mV restarts with soft start.
// - Routine runs about 200 us, then the done flag is set.
// - Enabled calibration applies and reads back the computed offset.
// - Disabled calibration applies written offset and ignores start requests.
`timescale 1ns/1ps
`include "dim_cal_defines.vh"

module dim_cal_ctrl #(
  parameter CAL_CYCLES = `CAL_CYCLES,
  parameter SS_CYCLES = `SOFT_START_CYCLES
) (
  input wire sys_clk_i,
  input wire rstn_i,
  input wire [3:0] addr_i,
  input wire [31:0] wdata_i,
  input wire wr_i,
  input wire rd_i,
  output reg [31:0] rdata_o,
  output wire irq_o,
  input wire limp_home_input_i,
  input wire enable_uv_input_i,
  input wire [1:0] direct_dim_input_i,
  input wire [1:0] set_below_low_i,
  input wire [1:0] set_above_high_i,
  input wire [15:0] cal_result_i,
  output reg [1:0] ext_reference_select_o,
  output reg [15:0] dac_level_o,
  output reg [15:0] cal_offset_value_o,
  output reg [1:0] switch_en_o,
  output reg [1:0] soft_start_o,
  output reg [1:0] cal_busy_o,
  output reg limp_home_o
);

  // ----------------------------------------------------------------
  // Input synchronisers
  // ----------------------------------------------------------------
  reg [5:0] sync1_q;
  reg [5:0] sync2_q;
  wire [5:0] pins_raw = {limp_home_input_i, enable_uv_input_i, direct_dim_input_i,
    set_below_low_i};

  always @(posedge sys_clk_i)
  begin
    if (!rstn_i)
    begin
      sync1_q <= 6'h00;
      sync2_q <= 6'h00;
    end
    else
    begin
      sync1_q <= pins_raw;
      sync2_q <= sync1_q;
    end
  end

  reg [1:0] hi1_q;
  reg [1:0] hi2_q;
  always @(posedge sys_clk_i)
  begin
    if (!rstn_i)
    begin
      hi1_q <= 2'h0;
      hi2_q <= 2'h0;
    end
    else
    begin
      hi1_q <= set_above_high_i;
      hi2_q <= hi1_q;
    end
  end

  wire limp_s = sync2_q[5];
  wire en_s = sync2_q[4];
  wire [1:0] pwm_s = sync2_q[3:2];
  wire [1:0] below_s = sync2_q[1:0];
  wire [1:0] above_s = hi2_q;

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  reg [7:0] dim_q [0:1];
  reg [1:0] extref_q;
  reg [7:0] cal_wr_q [0:1];
  reg [7:0] cal_res_q [0:1];
  reg [1:0] cal_done_q;
  reg [1:0] cal_en_q;
  reg [1:0] pwm_reg_q;
  reg [3:0] irq_st_q;
  reg [3:0] irq_msk_q;
  wire [3:0] irq_set;

  wire [1:0] cal_start_req;
  wire [1:0] cal_finish;
  wire [1:0] stop_ev;

  assign irq_o = |(irq_st_q & irq_msk_q);

  always @(posedge sys_clk_i)
  begin
    if (!rstn_i)
    begin
      limp_home_o <= 1'b0;
    end
    else
    begin
      limp_home_o <= limp_s;
    end
  end

  // ----------------------------------------------------------------
  // Per-channel logic
  // ----------------------------------------------------------------
  localparam ST_OFF = 3'b001;
  localparam ST_SS = 3'b010;
  localparam ST_RUN = 3'b100;

  genvar ch;
  generate
    for (ch = 0; ch < 2; ch = ch + 1)
    begin : g_ch
      reg [2:0] st_q;
      reg [2:0] st_d;
      reg [31:0] ss_cnt_q;
      reg [31:0] cal_cnt_q;
      reg stopped_q;
      reg cal_run_q;
      wire use_set = extref_q[ch] | limp_s;
      wire dim_zero = (dim_q[ch] == 8'h00) & ~use_set;
      wire pwm_ok = limp_s ? (pwm_s[ch] & en_s) : (pwm_s[ch] | pwm_reg_q[ch]);
      wire want = ~dim_zero & ~stopped_q & (~limp_s | en_s);
      wire wr_cal = wr_i && (addr_i == (ch ? `ADDR_CAL1 : `ADDR_CAL0));

      assign cal_start_req[ch] = wr_cal & wdata_i[`CAL_START_BIT] & cal_en_q[ch];
      assign cal_finish[ch] = cal_run_q && (cal_cnt_q == CAL_CYCLES - 1);
      assign stop_ev[ch] = (st_q != ST_OFF) && (st_d == ST_OFF);

      // Set-pin hysteresis: stop under low threshold, release over high threshold
      always @(posedge sys_clk_i)
      begin
        if (!rstn_i)
        begin
          stopped_q <= 1'b0;
        end
        else if (use_set && below_s[ch])
        begin
          stopped_q <= 1'b1;
        end
        else if (!use_set || above_s[ch])
        begin
          stopped_q <= 1'b0;
        end
      end

      always @*
      begin
        st_d = st_q;
        case (st_q)
          ST_OFF:
            if (want)
              st_d = ST_SS;
          ST_SS:
            if (!want)
              st_d = ST_OFF;
            else if (ss_cnt_q == SS_CYCLES - 1)
              st_d = ST_RUN;
          ST_RUN:
            if (!want)
              st_d = ST_OFF;
          default:
            st_d = ST_OFF;
        endcase
      end

      always @(posedge sys_clk_i)
      begin
        if (!rstn_i)
        begin
          st_q <= ST_OFF;
          ss_cnt_q <= 32'h0;
          cal_run_q <= 1'b0;
          cal_cnt_q <= 32'h0;
        end
        else
        begin
          st_q <= st_d;
          ss_cnt_q <= (st_q == ST_SS) ? ss_cnt_q + 32'h1 : 32'h0;
          if (cal_start_req[ch] && !cal_run_q)
          begin
            cal_run_q <= 1'b1;
            cal_cnt_q <= 32'h0;
          end
          else if (cal_finish[ch] || !cal_en_q[ch])
          begin
            cal_run_q <= 1'b0;
          end
          else if (cal_run_q)
          begin
            cal_cnt_q <= cal_cnt_q + 32'h1;
          end
        end
      end

      always @(posedge sys_clk_i)
      begin
        if (!rstn_i)
        begin
          switch_en_o[ch] <= 1'b0;
          soft_start_o[ch] <= 1'b0;
          ext_reference_select_o[ch] <= 1'b0;
          dac_level_o[8*ch+7:8*ch] <= 8'h00;
          cal_offset_value_o[8*ch+7:8*ch] <= 8'h00;
          cal_busy_o[ch] <= 1'b0;
        end
        else
        begin
          switch_en_o[ch] <= (st_q != ST_OFF) & pwm_ok & ~cal_run_q;
          soft_start_o[ch] <= (st_q == ST_SS);
          ext_reference_select_o[ch] <= use_set;
          dac_level_o[8*ch+7:8*ch] <= dim_q[ch];
          cal_offset_value_o[8*ch+7:8*ch] <= cal_en_q[ch] ? cal_res_q[ch] : cal_wr_q[ch];
          cal_busy_o[ch] <= cal_run_q;
        end
      end

      assign irq_set[2*ch+`IRQ_DONE_OFS] = cal_finish[ch];
      assign irq_set[2*ch+`IRQ_STOP_OFS] = stop_ev[ch];
    end
  endgenerate

  // ----------------------------------------------------------------
  // Register writes
  // ----------------------------------------------------------------
  integer i;
  always @(posedge sys_clk_i)
  begin
    if (!rstn_i)
    begin
      for (i = 0; i < 2; i = i + 1)
      begin
        dim_q[i] <= `DIM_RST;
        cal_wr_q[i] <= `CAL_VAL_RST;
        cal_res_q[i] <= `CAL_VAL_RST;
      end
      extref_q <= 2'h0;
      cal_done_q <= 2'h0;
      cal_en_q <= 2'h0;
      pwm_reg_q <= 2'h0;
      irq_msk_q <= 4'h0;
      irq_st_q <= 4'h0;
    end
    else if (limp_s)
    begin
      // Limp-home returns dim, written offset, reference select and loop registers to defaults; mask, results and done flags hold
      for (i = 0; i < 2; i = i + 1)
      begin
        dim_q[i] <= `DIM_RST;
        cal_wr_q[i] <= `CAL_VAL_RST;
      end
      extref_q <= 2'h0;
      cal_en_q <= 2'h0;
      pwm_reg_q <= 2'h0;
      irq_st_q <= irq_st_q | irq_set;
    end
    else
    begin
      for (i = 0; i < 2; i = i + 1)
      begin
        if (cal_start_req[i])
        begin
          cal_done_q[i] <= 1'b0;
        end
        if (cal_finish[i])
        begin
          cal_done_q[i] <= 1'b1;
          cal_res_q[i] <= cal_result_i[8*i+7 -: 8];
        end
      end
      if (wr_i && addr_i == `ADDR_DIM0)
        dim_q[0] <= wdata_i[7:0];
      else if (wr_i && addr_i == `ADDR_DIM1)
        dim_q[1] <= wdata_i[7:0];
      else if (wr_i && addr_i == `ADDR_CAL0)
      begin
        extref_q[0] <= wdata_i[`CAL_EXTREF_BIT];
        if (!cal_en_q[0])
          cal_wr_q[0] <= wdata_i[`CAL_VAL_LSB+7:`CAL_VAL_LSB];
      end
      else if (wr_i && addr_i == `ADDR_CAL1)
      begin
        extref_q[1] <= wdata_i[`CAL_EXTREF_BIT];
        if (!cal_en_q[1])
          cal_wr_q[1] <= wdata_i[`CAL_VAL_LSB+7:`CAL_VAL_LSB];
      end
      else if (wr_i && addr_i == `ADDR_LOOP)
      begin
        cal_en_q <= wdata_i[`LOOP_CALEN_LSB+1:`LOOP_CALEN_LSB];
        pwm_reg_q <= wdata_i[`LOOP_PWM_LSB+1:`LOOP_PWM_LSB];
      end
      else if (wr_i && addr_i == `ADDR_IRQ_MSK)
        irq_msk_q <= wdata_i[3:0];
      // Set wins over write-one-to-clear
      if (wr_i && addr_i == `ADDR_IRQ_ST)
        irq_st_q <= (irq_st_q & ~wdata_i[3:0]) | irq_set;
      else
        irq_st_q <= irq_st_q | irq_set;
    end
  end

  // ----------------------------------------------------------------
  // Register reads
  // ----------------------------------------------------------------
  function [31:0] cal_word;
    input extref;
    input done;
    input [7:0] val;
    begin
      cal_word = {16'h0000, val, 5'h00, done, 1'b0, extref};
    end
  endfunction

  always @(posedge sys_clk_i)
  begin
    if (!rstn_i)
      rdata_o <= 32'h00000000;
    else if (!rd_i)
      rdata_o <= 32'h00000000;
    else if (addr_i == `ADDR_DIM0)
      rdata_o <= {24'h000000, dim_q[0]};
    else if (addr_i == `ADDR_DIM1)
      rdata_o <= {24'h000000, dim_q[1]};
    else if (addr_i == `ADDR_CAL0)
      rdata_o <= cal_word(extref_q[0], cal_done_q[0],
        cal_en_q[0] ? cal_res_q[0] : cal_wr_q[0]);
    else if (addr_i == `ADDR_CAL1)
      rdata_o <= cal_word(extref_q[1], cal_done_q[1],
        cal_en_q[1] ? cal_res_q[1] : cal_wr_q[1]);
    else if (addr_i == `ADDR_LOOP)
      rdata_o <= {26'h0000000, pwm_reg_q, 2'h0, cal_en_q};
    else if (addr_i == `ADDR_STAT)
      rdata_o <= {24'h000000, 1'b0, limp_home_o, cal_busy_o, soft_start_o, switch_en_o};
    else if (addr_i == `ADDR_IRQ_ST)
      rdata_o <= {28'h0000000, irq_st_q};
    else if (addr_i == `ADDR_IRQ_MSK)
      rdata_o <= {28'h0000000, irq_msk_q};
    else
      rdata_o <= 32'h00000000;
  end

endmodule // dim_cal_ctrl

// ---- tb/dim_cal_checker.sv ----
// Checker for the dimming block, bound to its top ports.
// Assumes one clock and a synchronous active-low reset.
`timescale 1ns/1ps
module dim_cal_checker #(
  parameter CAL_CYCLES = 40000
) (
  input wire sys_clk_i,
  input wire rstn_i,
  input wire [3:0] addr_i,
  input wire [31:0] wdata_i,
  input wire wr_i,
  input wire limp_home_input_i,
  input wire enable_uv_input_i,
  input wire [1:0] set_below_low_i,
  input wire [1:0] ext_reference_select_o,
  input wire [15:0] dac_level_o,
  input wire [1:0] switch_en_o,
  input wire [1:0] cal_busy_o,
  input wire limp_home_o
);
  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (!rstn_i);
  reg [15:0] busy_q;
  always @(posedge sys_clk_i)
  begin
    busy_q <= (rstn_i && cal_busy_o[0]) ? busy_q + 16'h0001 : 16'h0000;
  end
  sequence s_set0_low;
    ext_reference_select_o[0] && set_below_low_i[0];
  endsequence
  sequence s_limp_off;
    limp_home_o && !enable_uv_input_i;
  endsequence
  property p_ext_ref;
    wr_i && addr_i == 4'h2 && wdata_i[0] |-> ##[1:3] ext_reference_select_o[0];
  endproperty
  property p_dim_level;
    wr_i && addr_i == 4'h0 && !limp_home_o
      |-> ##2 dac_level_o[7:0] == $past(wdata_i[7:0], 2);
  endproperty
  property p_zero_stop;
    wr_i && addr_i == 4'h0 && wdata_i[7:0] == 8'h00 && !ext_reference_select_o[0]
      |-> ##[1:4] !switch_en_o[0];
  endproperty
  property p_limp_pin;
    limp_home_o |-> $past(limp_home_input_i, 2) || $past(limp_home_input_i, 3)
      || $past(limp_home_input_i, 4);
  endproperty
  property p_limp_gate;
    s_limp_off [*6] |-> switch_en_o == 2'b00;
  endproperty
  property p_limp_ref;
    limp_home_o && $past(limp_home_o) |-> ext_reference_select_o == 2'b11;
  endproperty
  property p_set_stop;
    s_set0_low [*6] |-> !switch_en_o[0];
  endproperty
  property p_cal_time;
    cal_busy_o[0] |-> busy_q <= CAL_CYCLES;
  endproperty
  a_ext_ref: assert property (p_ext_ref) else $error("ext ref");
  a_dim_level: assert property (p_dim_level) else $error("dim level");
  a_zero_stop: assert property (p_zero_stop) else $error("zero stop");
  a_limp_pin: assert property (p_limp_pin) else $error("limp pin");
  a_limp_gate: assert property (p_limp_gate) else $error("limp gate");
  a_limp_ref: assert property (p_limp_ref) else $error("limp ref");
  a_set_stop: assert property (p_set_stop) else $error("set stop");
  a_cal_time: assert property (p_cal_time) else $error("cal time");
endmodule // dim_cal_checker
bind dim_cal_ctrl dim_cal_checker #(.CAL_CYCLES(CAL_CYCLES)) u_checker (
  .sys_clk_i, .rstn_i, .addr_i, .wdata_i, .wr_i, .limp_home_input_i, .enable_uv_input_i,
  .set_below_low_i, .ext_reference_select_o, .dac_level_o, .switch_en_o, .cal_busy_o,
  .limp_home_o);

// ---- tb/set_pin_model.sv ----
// Analog side model: set-pin comparators and the calibration result.
// Assumes set-pin voltages in millivolts come from the bench.
`timescale 1ns/1ps
module set_pin_model #(
  parameter RESULT0 = 8'h5A,
  parameter RESULT1 = 8'hC3
) (
  input wire [10:0] set0_mv_i,
  input wire [10:0] set1_mv_i,
  output wire [1:0] set_below_low_o,
  output wire [1:0] set_above_high_o,
  output wire [15:0] cal_result_o
);
  assign set_below_low_o = {set1_mv_i < 11'h064, set0_mv_i < 11'h064};
  assign set_above_high_o = {set1_mv_i > 11'h0C8, set0_mv_i > 11'h0C8};
  assign cal_result_o = {RESULT1, RESULT0};
endmodule // set_pin_model

// ---- tb/dim_cal_ctrl_tb.sv ----
// Bench for the dimming and calibration block with a set-pin model.
// Assumes the checker is bound in and the model file is compiled.
`timescale 1ns/1ps
module dim_cal_ctrl_tb;
  localparam CAL = 50;
  reg sys_clk_i = 1'b0;
  reg rstn_i = 1'b0;
  reg [3:0] addr = 4'h0;
  reg [31:0] wdat = 32'h0;
  reg wstb = 1'b0;
  reg rstb = 1'b0;
  reg limp = 1'b0;
  reg en = 1'b1;
  reg [1:0] pwm = 2'h3;
  reg [10:0] mv = 11'h12C;
  reg [31:0] seed = 32'hABFE61A7;
  wire [31:0] rdata;
  wire irq, limp_o;
  wire [1:0] lo, hi, xref, sw, ss, busy;
  wire [15:0] res, dac, ofs;
  integer errors = 0;
  integer checked = 0;
  integer cycles = 0;
  integer k, i;
  set_pin_model u_pins (.set0_mv_i(mv), .set1_mv_i(11'h12C), .set_below_low_o(lo),
    .set_above_high_o(hi), .cal_result_o(res));
  dim_cal_ctrl #(.CAL_CYCLES(CAL), .SS_CYCLES(8)) dut (.sys_clk_i(sys_clk_i),
    .rstn_i(rstn_i), .addr_i(addr), .wdata_i(wdat), .wr_i(wstb), .rd_i(rstb),
    .rdata_o(rdata), .irq_o(irq), .limp_home_input_i(limp), .enable_uv_input_i(en),
    .direct_dim_input_i(pwm), .set_below_low_i(lo), .set_above_high_i(hi),
    .cal_result_i(res), .ext_reference_select_o(xref), .dac_level_o(dac),
    .cal_offset_value_o(ofs), .switch_en_o(sw), .soft_start_o(ss), .cal_busy_o(busy),
    .limp_home_o(limp_o));
  always #2.5 sys_clk_i = ~sys_clk_i;
  always @(posedge sys_clk_i)
  begin
    cycles = cycles + 1;
    if (cycles == 5000)
    begin
      errors = errors + 1;
      results;
    end
  end
  // ----
  // Helpers
  // ----
  function [31:0] lfsr(input [31:0] s);
    lfsr = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  function [31:0] cal_word(input [7:0] o, input done);
    cal_word = {16'h0000, o, 5'h00, done, 2'h0};
  endfunction
  task chk(input string n, input [31:0] got, input [31:0] exp);
  begin
    checked = checked + 1;
    if (got !== exp)
    begin
      errors = errors + 1;
      $display("MISMATCH %s expected %h seen %h", n, exp, got);
    end
  end
  endtask
  task reg_wr(input [3:0] a, input [31:0] d);
  begin
    addr <= a;
    wdat <= d;
    wstb <= 1'b1;
    @(posedge sys_clk_i);
    wstb <= 1'b0;
    @(posedge sys_clk_i);
  end
  endtask
  task reg_rd(input [3:0] a, input [31:0] m, input [31:0] exp);
  begin
    addr <= a;
    rstb <= 1'b1;
    @(posedge sys_clk_i);
    rstb <= 1'b0;
    @(posedge sys_clk_i);
    chk("rdata", rdata & m, exp);
  end
  endtask
  task cyc(input integer n);
  begin
    repeat (n) @(posedge sys_clk_i);
  end
  endtask
  // Waits for soft start (0) or the end of a calibration (1)
  task poll(input integer s);
  begin
    k = 0;
    while (k < 200 && (s == 0 ? ss[0] !== 1'b1 : busy[0] !== 1'b0))
    begin
      @(posedge sys_clk_i);
      k = k + 1;
    end
  end
  endtask
  task results;
  begin
    if (errors == 0 && checked > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  end
  endtask
  // ----
  // Scenarios
  // ----
  initial
  begin
    repeat (3) @(posedge sys_clk_i);
    rstn_i <= 1'b1;
    @(posedge sys_clk_i);
    reg_rd(4'h0, 32'hFFFFFFFF, 32'h000000FF);
    reg_rd(4'hA, 32'hFFFFFFFF, 32'h00000000);
    for (i = 0; i < 8; i = i + 1)
    begin
      seed = lfsr(seed);
      reg_wr(4'h0, {24'h000000, seed[7:0] | 8'h01});
      reg_wr(4'h1, {24'h000000, seed[15:8] | 8'h01});
      reg_rd(4'h0, 32'hFF, seed[7:0] | 8'h01);
      chk("dac", dac, {seed[15:8] | 8'h01, seed[7:0] | 8'h01});
    end
    reg_wr(4'h7, 32'h0);
    reg_wr(4'h0, 32'h0);
    cyc(4);
    chk("sw0", sw[0], 1'b0);
    chk("irq", irq, 1'b0);
    reg_rd(4'h6, 32'h2, 32'h2);
    reg_wr(4'h7, 32'h2);
    chk("irq", irq, 1'b1);
    reg_wr(4'h6, 32'h2);
    chk("irq", irq, 1'b0);
    reg_wr(4'h0, 32'h18);
    poll(0);
    chk("ss0", ss[0], 1'b1);
    reg_wr(4'h2, 32'h1);
    cyc(2);
    chk("xref", xref, 2'b01);
    mv <= 11'h032;
    cyc(8);
    chk("sw0", sw[0], 1'b0);
    mv <= 11'h096;
    cyc(8);
    chk("sw0", sw[0], 1'b0);
    mv <= 11'h0FA;
    poll(0);
    chk("ss0", ss[0], 1'b1);
    pwm <= 2'h0;
    reg_wr(4'h2, 32'h3300);
    // Start request with calibration disabled; the offset field is rewritten unchanged
    reg_wr(4'h2, 32'h3302);
    cyc(4);
    chk("busy", busy, 2'b00);
    chk("ofs0", ofs[7:0], 8'h33);
    reg_rd(4'h2, 32'hFFFF, cal_word(8'h33, 1'b0));
    reg_wr(4'h4, 32'h1);
    reg_rd(4'h4, 32'h33, 32'h01);
    reg_wr(4'h2, 32'h3302);
    cyc(1);
    chk("busy", busy, 2'b01);
    poll(1);
    chk("time", (k >= CAL - 4) && (k <= CAL), 1'b1);
    reg_rd(4'h2, 32'hFFFF, cal_word(8'h5A, 1'b1));
    chk("ofs", ofs, 16'h005A);
    reg_rd(4'h6, 32'h1, 32'h1);
    reg_wr(4'h4, 32'h0);
    limp <= 1'b1;
    pwm <= 2'h1;
    cyc(6);
    chk("limp", limp_o, 1'b1);
    chk("xref", xref, 2'b11);
    chk("sw1", sw[1], 1'b0);
    reg_rd(4'h5, 32'h40, 32'h40);
    reg_wr(4'h0, 32'h11);
    reg_rd(4'h0, 32'hFF, 32'hFF);
    en <= 1'b0;
    cyc(6);
    chk("sw", sw, 2'b00);
    limp <= 1'b0;
    en <= 1'b1;
    cyc(6);
    chk("limp", limp_o, 1'b0);
    results;
  end
endmodule // dim_cal_ctrl_tb
